// ==== bench/sfw_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// link and status checks
// ****
module sfw_props (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic [7:0] po,
    input wire logic wp_n,
    input wire logic [7:0] STATUS,
    input wire logic HW_PROTECT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    // eight-cycle phases keep sck under the byte-wide limit
    sequence s_high; sck [*8] ##1 !sck; endsequence
    property p_rate; $rose(sck) |-> s_high; endproperty
    a_rate: assert property (p_rate) else $error("sck phase");
    property p_end; $rose(cs_n) |-> !sck && !$past(sck, 7); endproperty
    a_end: assert property (p_end) else $error("select rose mid bit");
    property p_zero; STATUS[6:5] == 2'b00; endproperty
    a_zero: assert property (p_zero) else $error("bits 6 5 set");
    property p_wel; $rose(STATUS[1]) |-> cs_n; endproperty
    a_wel: assert property (p_wel) else $error("latch set in frame");
    property p_done; $fell(STATUS[0]) |-> !STATUS[1]; endproperty
    a_done: assert property (p_done) else $error("latch kept");
    property p_bits; $changed(STATUS[7:2]) |-> cs_n; endproperty
    a_bits: assert property (p_bits) else $error("status moved in frame");
    property p_hw; HW_PROTECT |-> STATUS[7]; endproperty
    a_hw: assert property (p_hw) else $error("protect without bit");
    // the pin sync costs three cycles, so six steady cycles settle the mode
    property p_leave; wp_n [*6] |=> !HW_PROTECT; endproperty
    a_leave: assert property (p_leave) else $error("protect kept");
    // data may only move while the serial clock is low, so every rise sees settled bits
    property p_hold; sck |-> $stable(si) && $stable(po); endproperty
    a_hold: assert property (p_hold) else $error("data moved with sck high");
endmodule : sfw_props
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// host and flash ends face each other
// ****
module tb;
    logic core_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, data_valid = 1'b0, wp_n_in = 1'b1;
    logic cmd_ready, data_ready, done, busy, par_d, hw_prot, ok, pr, write_enable_latch = 1'b0, par = 1'b0;
    logic par_h, bz;
    logic [7:0] cmd_op = 8'h00, data_in = 8'h00, st = 8'h00, rd_data, status, dq[$], pg[256];
    logic [23:0] cmd_addr = 24'h00_0000;
    logic [8:0] cmd_len = 9'h000;
    logic [9:0] rd_addr = 10'h000;
    logic [31:0] rs = 32'h0000_4650;
    int n_mismatch = 0, n_checks = 0, mem[1024];
    sfw_if link ();
    sfw_host sfw_host_i (.CORE_CLK(core_clk), .RESETN(resetn), .LINK(link),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr),
        .CMD_LEN(cmd_len), .DATA_VALID(data_valid), .DATA_IN(data_in),
        .DATA_READY(data_ready), .WP_N_IN(wp_n_in), .DONE(done), .PAR_MODE(par_h));
    // short timed counts keep the run brief
    sfw_dev #(.PROGRAM_CYCLES(36'h0_0000_0032), .SECTOR_ERASE_CYCLES(36'h0_0000_003C),
        .BULK_ERASE_CYCLES(36'h0_0000_0046), .STATUS_WRITE_CYCLES(36'h0_0000_0014))
        sfw_dev_i (.CORE_CLK(core_clk), .RESETN(resetn), .LINK(link), .RD_ADDR(rd_addr),
        .RD_DATA(rd_data), .STATUS(status), .BUSY(busy), .PAR_MODE(par_d),
        .HW_PROTECT(hw_prot));
    sfw_props sfw_props_i (.CORE_CLK(core_clk), .RESETN(resetn), .cs_n(link.cs_n),
        .sck(link.sck), .si(link.si), .po(link.po), .wp_n(link.wp_n), .STATUS(status),
        .HW_PROTECT(hw_prot));
    initial forever #5 core_clk = ~core_clk;
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction : rnd
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (e !== s) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // reference model of status and array, updated once a frame has settled
    task automatic model(input logic [7:0] op, input logic [23:0] a);
        pr = st[4:2] != 3'b000 && a[9:0] >= 10'(1024 - (1024 >> (7 - st[4:2])));
        pg = '{default: 8'hFF};
        foreach (dq[i]) pg[(a[7:0] + i) % 256] = dq[i];
        case (op)
            8'h01: ok = write_enable_latch && (wp_n_in || !st[7]);
            8'h02, 8'hD8: ok = write_enable_latch && !pr;
            8'hC7: ok = write_enable_latch && st[4:2] == 3'b000;
            default: ok = 1'b0;
        endcase
        if (ok && op == 8'h01) st = dq[0] & 8'h9C;
        if (ok && op == 8'h02) foreach (pg[j]) mem[a[9:8] * 256 + j] &= pg[j];
        if (ok && op == 8'hD8) for (int j = 0; j < 512; j++) mem[a[9] * 512 + j] = 255;
        if (ok && op == 8'hC7) foreach (mem[j]) mem[j] = 255;
        if (ok) write_enable_latch = 1'b0;
        if (op == 8'h06) write_enable_latch = 1'b1;
        if (op == 8'h55 || op == 8'h45) par = op[4];
    endtask : model
    // request held until the edge that samples ready; the user waits out busy
    task automatic cmd(input logic [7:0] op, input logic [23:0] a);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_len <= 9'(dq.size());
        cmd_valid <= 1'b1;
        do @(posedge core_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        foreach (dq[i]) begin
            data_valid <= 1'b1;
            data_in <= dq[i];
            do @(posedge core_clk); while (data_ready !== 1'b1);
        end
        data_valid <= 1'b0;
        while (done !== 1'b1) @(posedge core_clk);
        // a timed job started at select rise must already show busy here
        bz = busy;
        @(posedge core_clk);
        while (busy !== 1'b0) @(posedge core_clk);
        model(op, a);
        chk("status", {st[7], 2'b00, st[4:2], write_enable_latch, 1'b0}, status);
        chk("par_mode", {7'h00, par}, {7'h00, par_d});
        chk("host_par", {7'h00, par}, {7'h00, par_h});
        chk("busy", {7'h00, ok}, {7'h00, bz});
    endtask : cmd
    // optional latch set, then the op; a status write carries its value in a[7:0]
    task automatic wcmd(input logic [7:0] op, input logic [23:0] a, input int n, input bit en);
        dq.delete();
        if (en) cmd(8'h06, 24'h00_0000);
        repeat (n) dq.push_back(rnd());
        if (op == 8'h01) dq = '{a[7:0]};
        cmd(op, a);
    endtask : wcmd
    task automatic setwp(input logic b);
        wp_n_in <= b;
        repeat (8) @(posedge core_clk);
        chk("hw_protect", {7'h00, !b && st[7]}, {7'h00, hw_prot});
    endtask : setwp
    task automatic chk_mem();
        for (int a = 0; a < 1024; a++) begin
            rd_addr <= 10'(a);
            repeat (2) @(posedge core_clk);
            chk("array", 8'(mem[a]), rd_data);
        end
    endtask : chk_mem
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    // a hung handshake would stall the sequence forever; the run needs about 22,000
    // cycles, so 60,000 leaves room without running long
    initial begin
        #600000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        foreach (mem[j]) mem[j] = 255;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        wcmd(8'h01, 24'h00_00FC, 0, 1'b0);
        setwp(1'b0);
        wcmd(8'h01, 24'h00_00FF, 0, 1'b1);
        setwp(1'b0);
        wcmd(8'h01, 24'h00_0000, 0, 1'b1);
        wcmd(8'hC7, 24'h00_0000, 0, 1'b1);
        setwp(1'b1);
        wcmd(8'h01, 24'h00_0004, 0, 1'b1);
        wcmd(8'h02, 24'h00_03F8, 2, 1'b1);
        wcmd(8'hD8, 24'h00_03F0, 0, 1'b1);
        wcmd(8'h02, 24'h00_0110, 20, 1'b1);
        wcmd(8'h01, 24'h00_0080, 0, 1'b1);
        setwp(1'b0);
        wcmd(8'h02, 24'h00_0205, 5, 1'b1);
        setwp(1'b1);
        chk_mem();
        wcmd(8'h60, 24'h00_0000, 0, 1'b1);
        wcmd(8'hD8, 24'h00_0123, 0, 1'b0);
        wcmd(8'h55, 24'h00_0000, 0, 1'b0);
        wcmd(8'h02, 24'h00_0010, 300, 1'b1);
        wcmd(8'h01, 24'h00_0000, 0, 1'b1);
        chk_mem();
        wcmd(8'h45, 24'h00_0000, 0, 1'b0);
        wcmd(8'hC7, 24'h00_0000, 0, 1'b1);
        chk_mem();
        stop_test();
    end
endmodule : tb
`default_nettype wire

// ==== core/sfw_dev.sv ====
`timescale 1ns/1ps
`default_nettype none

module sfw_dev #(
    parameter int MEM_BYTES = sfw_pkg::MEM_BYTES_DEF,
    parameter int SECTOR_BYTES = sfw_pkg::SECTOR_BYTES_DEF,
    parameter bit SMALL_SECTORS = 1'b0,
    parameter logic [sfw_pkg::TIMER_W-1:0] PROGRAM_CYCLES = sfw_pkg::PROGRAM_CYCLES,
    parameter logic [sfw_pkg::TIMER_W-1:0] SECTOR_ERASE_CYCLES = sfw_pkg::SECTOR_ERASE_CYCLES,
    parameter logic [sfw_pkg::TIMER_W-1:0] BULK_ERASE_CYCLES = sfw_pkg::BULK_ERASE_CYCLES,
    parameter logic [sfw_pkg::TIMER_W-1:0] STATUS_WRITE_CYCLES = sfw_pkg::STATUS_WRITE_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    sfw_if.dev LINK,
    input wire logic [$clog2(MEM_BYTES)-1:0] RD_ADDR,
    output logic [7:0] RD_DATA,
    output logic [7:0] STATUS,
    output logic BUSY,
    output logic PAR_MODE,
    output logic HW_PROTECT
);

    localparam int AW = $clog2(MEM_BYTES);
    localparam int PAGE = sfw_pkg::PAGE_BYTES;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0] sck_s;             // [0] first stage, [2] edge history
        logic [2:0] cs_s;
        logic [1:0] si_s;
        logic [1:0] wp_s;
        logic [1:0][7:0] po_s;
        logic [7:0] shreg;
        logic [2:0] bitcnt;
        logic [3:0] nbytes;            // saturating byte count in frame
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [7:0] wr_ptr;
        logic [PAGE-1:0] buf_vld;
        logic [PAGE-1:0][7:0] pbuf;
        logic [7:0] status;
        logic par;
        logic hardware_protected_mode;
        logic [sfw_pkg::TIMER_W-1:0] timer;
        logic [MEM_BYTES-1:0][7:0] mem;
        logic [7:0] rd_data;
    } sfw_dev_state_t;

    // erased array, select idle high, everything else clear
    localparam sfw_dev_state_t S_RST = '{
        mem: '1, cs_s: '1, sck_s: '0, si_s: '0, wp_s: '0, po_s: '0,
        shreg: '0, bitcnt: '0, nbytes: '0, cmd: '0, addr: '0, wr_ptr: '0,
        buf_vld: '0, pbuf: '0, status: sfw_pkg::STATUS_RESET, par: 1'b0,
        hardware_protected_mode: 1'b0, timer: '0, rd_data: '0
    };

    sfw_dev_state_t s;
    sfw_dev_state_t next_s;
    logic sck_rise;
    logic cs_rise;
    logic cs_fall;
    logic byte_done;
    logic [7:0] in_byte;
    logic write_enable_latch;
    logic [2:0] bp;
    logic prot;
    int lim;
    int a_int;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        // two flops on every pin before any logic reads it
        next_s.sck_s = {s.sck_s[1:0], LINK.sck};
        next_s.cs_s = {s.cs_s[1:0], LINK.cs_n};
        next_s.si_s = {s.si_s[0], LINK.si};
        next_s.wp_s = {s.wp_s[0], LINK.wp_n};
        next_s.po_s = {s.po_s[0], LINK.po};
        sck_rise = s.sck_s[1] & ~s.sck_s[2];
        cs_rise = s.cs_s[1] & ~s.cs_s[2];
        cs_fall = ~s.cs_s[1] & s.cs_s[2];
        write_enable_latch = s.status[sfw_pkg::ST_WEL];
        bp = s.status[sfw_pkg::ST_BP_HI:sfw_pkg::ST_BP_LO];
        a_int = int'(s.addr[AW-1:0]);
        // upper region, 1/64 of the array at 001 up to all of it at 111
        lim = MEM_BYTES - (MEM_BYTES >> (7 - int'(bp)));
        prot = (bp != 3'h0) && (a_int >= lim);
        in_byte = s.par ? s.po_s[1] : {s.shreg[6:0], s.si_s[1]};
        byte_done = 1'b0;

        // shift in bits, or whole bytes in byte-wide mode
        if (cs_fall) begin
            next_s.bitcnt = 3'h0;
            next_s.nbytes = 4'h0;
            next_s.buf_vld = '0;
        end else if (!s.cs_s[1] && sck_rise) begin
            next_s.shreg = in_byte;
            next_s.bitcnt = s.par ? 3'h0 : s.bitcnt + 3'h1;
            byte_done = s.par || (s.bitcnt == 3'h7);
        end

        // place each finished byte: command, address msb first, data
        if (byte_done) begin
            if (s.nbytes != sfw_pkg::NBYTES_MAX) begin
                next_s.nbytes = s.nbytes + 4'h1;
            end
            case (s.nbytes)
                4'h0: begin
                    next_s.cmd = in_byte;
                end
                4'h1: begin
                    next_s.addr[23:16] = in_byte; // also the status data byte
                end
                4'h2: begin
                    next_s.addr[15:8] = in_byte;
                end
                4'h3: begin
                    next_s.addr[7:0] = in_byte;
                    next_s.wr_ptr = in_byte;
                end
                default: begin
                    // extra bytes wrap and overwrite, so the last 256 win
                    if (s.cmd == sfw_pkg::CMD_PAGE_PROGRAM) begin
                        next_s.pbuf[s.wr_ptr] = in_byte;
                        next_s.buf_vld[s.wr_ptr] = 1'b1;
                        next_s.wr_ptr = s.wr_ptr + 8'h01;
                    end
                end
            endcase
        end

        // timed operation running; a command whose select rises now is dropped, not held
        if (s.status[sfw_pkg::ST_BUSY]) begin
            if (s.timer <= sfw_pkg::TIMER_W'(1)) begin
                next_s.status[sfw_pkg::ST_BUSY] = 1'b0;
                next_s.timer = '0;
            end else begin
                next_s.timer = s.timer - sfw_pkg::TIMER_W'(1);
            end
        end else if (cs_rise && s.bitcnt == 3'h0) begin
            // select rise off a byte boundary drops the frame
            case (s.cmd)
                sfw_pkg::CMD_WRITE_ENABLE: begin
                    if (s.nbytes == 4'(sfw_pkg::ONE_BYTE)) begin
                        next_s.status[sfw_pkg::ST_WEL] = 1'b1;
                    end
                end
                sfw_pkg::CMD_WRITE_DISABLE: begin
                    if (s.nbytes == 4'(sfw_pkg::ONE_BYTE)) begin
                        next_s.status[sfw_pkg::ST_WEL] = 1'b0;
                    end
                end
                sfw_pkg::CMD_PAR_ENTER: begin
                    if (s.nbytes == 4'(sfw_pkg::ONE_BYTE)) begin
                        next_s.par = 1'b1;
                    end
                end
                sfw_pkg::CMD_PAR_EXIT: begin
                    if (s.nbytes == 4'(sfw_pkg::ONE_BYTE)) begin
                        next_s.par = 1'b0;
                    end
                end
                sfw_pkg::CMD_STATUS_WRITE: begin
                    // only status_write_disable_bit and block protect take the data byte
                    if (s.nbytes == 4'(sfw_pkg::SW_BYTES) && write_enable_latch && !s.hardware_protected_mode) begin
                        next_s.status = (s.status & ~sfw_pkg::STATUS_WRITE_MASK) |
                            (s.addr[23:16] & sfw_pkg::STATUS_WRITE_MASK);
                        next_s.status[sfw_pkg::ST_BUSY] = 1'b1;
                        next_s.status[sfw_pkg::ST_WEL] = 1'b0;
                        next_s.timer = STATUS_WRITE_CYCLES;
                    end
                end
                sfw_pkg::CMD_PAGE_PROGRAM: begin
                    if (s.nbytes >= 4'(sfw_pkg::PP_MIN_BYTES) && write_enable_latch && !prot) begin
                        for (int i = 0; i < MEM_BYTES; i++) begin
                            if ((i / PAGE) == (a_int / PAGE) && s.buf_vld[i % PAGE]) begin
                                next_s.mem[i] = s.mem[i] & s.pbuf[i % PAGE];
                            end
                        end
                        next_s.status[sfw_pkg::ST_BUSY] = 1'b1;
                        next_s.status[sfw_pkg::ST_WEL] = 1'b0;
                        next_s.timer = PROGRAM_CYCLES;
                    end
                end
                sfw_pkg::CMD_SECTOR_ERASE, sfw_pkg::CMD_SECTOR_ERASE_SMALL: begin
                    if (s.nbytes == 4'(sfw_pkg::SE_BYTES) && write_enable_latch && !prot &&
                        (SMALL_SECTORS || s.cmd == sfw_pkg::CMD_SECTOR_ERASE)) begin
                        for (int i = 0; i < MEM_BYTES; i++) begin
                            if ((i / SECTOR_BYTES) == (a_int / SECTOR_BYTES)) begin
                                next_s.mem[i] = 8'hFF;
                            end
                        end
                        next_s.status[sfw_pkg::ST_BUSY] = 1'b1;
                        next_s.status[sfw_pkg::ST_WEL] = 1'b0;
                        next_s.timer = SECTOR_ERASE_CYCLES;
                    end
                end
                sfw_pkg::CMD_BULK_ERASE, sfw_pkg::CMD_BULK_ERASE_SMALL: begin
                    if (s.nbytes == 4'(sfw_pkg::ONE_BYTE) && write_enable_latch && bp == 3'h0 &&
                        (SMALL_SECTORS || s.cmd == sfw_pkg::CMD_BULK_ERASE)) begin
                        next_s.mem = '1;
                        next_s.status[sfw_pkg::ST_BUSY] = 1'b1;
                        next_s.status[sfw_pkg::ST_WEL] = 1'b0;
                        next_s.timer = BULK_ERASE_CYCLES;
                    end
                end
                default: begin
                end
            endcase
        end

        // level decode, so the order of pin and bit does not matter
        next_s.hardware_protected_mode = ~s.wp_s[1] & next_s.status[sfw_pkg::ST_STATUS_WRITE_DISABLE_BIT];
        next_s.rd_data = s.mem[RD_ADDR];
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= S_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from state
    assign RD_DATA = s.rd_data;
    assign STATUS = s.status;
    assign BUSY = s.status[sfw_pkg::ST_BUSY];
    assign PAR_MODE = s.par;
    assign HW_PROTECT = s.hardware_protected_mode;

endmodule : sfw_dev
`default_nettype wire

// ==== core/sfw_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// host end: frames commands onto the link, makes the serial clock
module sfw_host (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    sfw_if.host LINK,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic [7:0] CMD_OP,
    input wire logic [23:0] CMD_ADDR,
    input wire logic [8:0] CMD_LEN,
    input wire logic DATA_VALID,
    input wire logic [7:0] DATA_IN,
    output logic DATA_READY,
    input wire logic WP_N_IN,
    output logic DONE,
    output logic PAR_MODE
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOW = 3'b001,
        H_HIGH = 3'b010,
        H_FETCH = 3'b011,
        H_TAIL = 3'b100,
        H_GAP = 3'b101
    } sfw_host_fsm_t;

    typedef struct packed {
        sfw_host_fsm_t st;
        logic cs_n;
        logic sck;
        logic [7:0] tx;
        logic [7:0] op;
        logic [2:0] bitcnt;
        logic [1:0] hdr;
        logic [23:0] hdr_buf;
        logic [8:0] left;
        logic [3:0] cnt;
        logic par;
        logic wp_n;
        logic cmd_ready;
        logic data_ready;
        logic done;
    } sfw_host_state_t;

    localparam sfw_host_state_t H_RST = '{
        st: H_IDLE, cs_n: 1'b1, sck: 1'b0, tx: '0, op: '0, bitcnt: '0, hdr: '0,
        hdr_buf: '0, left: '0, cnt: '0, par: 1'b0, wp_n: 1'b1,
        cmd_ready: 1'b0, data_ready: 1'b0, done: 1'b0
    };

    sfw_host_state_t s;
    sfw_host_state_t next_s;
    logic needs_addr;

    always_comb begin
        next_s = s;
        next_s.data_ready = 1'b0;
        next_s.done = 1'b0;
        next_s.wp_n = WP_N_IN;
        needs_addr = (CMD_OP == sfw_pkg::CMD_PAGE_PROGRAM) ||
            (CMD_OP == sfw_pkg::CMD_SECTOR_ERASE) ||
            (CMD_OP == sfw_pkg::CMD_SECTOR_ERASE_SMALL);
        case (s.st)
            H_IDLE: begin
                next_s.cmd_ready = 1'b1;
                if (CMD_VALID && s.cmd_ready) begin
                    next_s.cmd_ready = 1'b0;
                    next_s.cs_n = 1'b0; // select held low for the whole frame
                    next_s.tx = CMD_OP;
                    next_s.op = CMD_OP;
                    next_s.hdr_buf = CMD_ADDR;
                    next_s.hdr = needs_addr ? 2'h3 : 2'h0;
                    next_s.left = CMD_LEN;
                    next_s.bitcnt = 3'h0;
                    next_s.cnt = sfw_pkg::SCK_HALF_LAST;
                    next_s.st = H_LOW;
                end
            end
            H_LOW: begin
                if (s.cnt == 4'h0) begin
                    next_s.sck = 1'b1;
                    next_s.cnt = sfw_pkg::SCK_HALF_LAST;
                    next_s.st = H_HIGH;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            H_HIGH: begin
                if (s.cnt != 4'h0) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else begin
                    next_s.sck = 1'b0;
                    next_s.cnt = sfw_pkg::SCK_HALF_LAST;
                    if (!s.par && s.bitcnt != 3'h7) begin
                        next_s.tx = {s.tx[6:0], 1'b0};
                        next_s.bitcnt = s.bitcnt + 3'h1;
                        next_s.st = H_LOW;
                    end else if (s.hdr != 2'h0) begin
                        // address goes out most significant byte first
                        next_s.tx = s.hdr_buf[23:16];
                        next_s.hdr_buf = {s.hdr_buf[15:0], 8'h00};
                        next_s.hdr = s.hdr - 2'h1;
                        next_s.bitcnt = 3'h0;
                        next_s.st = H_LOW;
                    end else if (s.left != 9'h000) begin
                        next_s.bitcnt = 3'h0;
                        next_s.st = H_FETCH;
                    end else begin
                        next_s.st = H_TAIL;
                    end
                end
            end
            H_FETCH: begin
                // clock stands low while the source has nothing
                if (DATA_VALID) begin
                    next_s.tx = DATA_IN;
                    next_s.data_ready = 1'b1;
                    next_s.left = s.left - 9'h001;
                    next_s.cnt = sfw_pkg::SCK_HALF_LAST;
                    next_s.st = H_LOW;
                end
            end
            H_TAIL: begin
                // release select one low half period (eight cycles) after the last whole byte
                if (s.cnt == 4'h0) begin
                    next_s.cs_n = 1'b1;
                    next_s.cnt = sfw_pkg::CS_GAP_LAST;
                    if (s.op == sfw_pkg::CMD_PAR_ENTER) begin
                        next_s.par = 1'b1;
                    end else if (s.op == sfw_pkg::CMD_PAR_EXIT) begin
                        next_s.par = 1'b0;
                    end
                    next_s.st = H_GAP;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            H_GAP: begin
                if (s.cnt == 4'h0) begin
                    next_s.done = 1'b1;
                    next_s.st = H_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            default: begin
                next_s = H_RST;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= H_RST;
        end else begin
            s <= next_s;
        end
    end

    // link pins; serial data is always the msb of the shifter
    assign LINK.cs_n = s.cs_n;
    assign LINK.sck = s.sck;
    assign LINK.si = s.tx[7];
    assign LINK.po = s.tx;
    assign LINK.wp_n = s.wp_n;
    assign CMD_READY = s.cmd_ready;
    assign DATA_READY = s.data_ready;
    assign DONE = s.done;
    assign PAR_MODE = s.par;

endmodule : sfw_host
`default_nettype wire

// ==== core/sfw_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// serial link between host and flash sequencer
interface sfw_if;
    logic cs_n;
    logic sck;
    logic si;
    logic [7:0] po;   // parallel_byte_port
    logic wp_n;       // write_protect_pin

    modport dev (input cs_n, input sck, input si, input po, input wp_n);
    modport host (output cs_n, output sck, output si, output po, output wp_n);
endinterface : sfw_if
`default_nettype wire

// ==== core/sfw_pkg.sv ====
`default_nettype none
package sfw_pkg;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_SECTOR_ERASE_SMALL = 8'h20;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] CMD_BULK_ERASE = 8'hC7;
    localparam logic [7:0] CMD_BULK_ERASE_SMALL = 8'h60;
    localparam logic [7:0] CMD_PAR_ENTER = 8'h55;
    localparam logic [7:0] CMD_PAR_EXIT = 8'h45;

    // ****************************************
    // status_protect_register layout
    // ****************************************
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 4;
    localparam int ST_STATUS_WRITE_DISABLE_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STATUS_WRITE_MASK = 8'h9C; // status_write_disable_bit and block protect only

    // ****************************************
    // array geometry and frame layout
    // ****************************************
    localparam int PAGE_BYTES = 256;
    localparam int MEM_BYTES_DEF = 1024;
    localparam int SECTOR_BYTES_DEF = 512;
    localparam int PP_MIN_BYTES = 5;  // command, three address, one data
    localparam int SE_BYTES = 4;
    localparam int SW_BYTES = 2;
    localparam int ONE_BYTE = 1;
    localparam logic [3:0] NBYTES_MAX = 4'hF;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int PROGRAM_TIME_US = 1500;
    localparam int SECTOR_ERASE_TIME_MS = 2000;
    localparam int BULK_ERASE_TIME_S = 128;
    localparam int STATUS_WRITE_TIME_NS = 1000;
    localparam int TIMER_W = 36;
    localparam logic [TIMER_W-1:0] PROGRAM_CYCLES =
        TIMER_W'(longint'(PROGRAM_TIME_US) * CLK_MHZ);
    localparam logic [TIMER_W-1:0] SECTOR_ERASE_CYCLES =
        TIMER_W'(longint'(SECTOR_ERASE_TIME_MS) * 1000 * CLK_MHZ);
    localparam logic [TIMER_W-1:0] BULK_ERASE_CYCLES =
        TIMER_W'(longint'(BULK_ERASE_TIME_S) * 1000000 * CLK_MHZ);
    localparam logic [TIMER_W-1:0] STATUS_WRITE_CYCLES =
        TIMER_W'((STATUS_WRITE_TIME_NS * CLK_MHZ + 999) / 1000);
    // host link clock: 16 core cycles per serial clock, 6.25 MHz, under 10 MHz
    localparam logic [3:0] SCK_HALF_LAST = 4'h7;
    localparam logic [3:0] CS_GAP_LAST = 4'hF;

endpackage : sfw_pkg
`default_nettype wire
